// [pces_pkg.sv]
package pces_pkg;
    // Wishbone word offsets (byte addresses)
    localparam logic [7:0]  STATUS_LO_OFS     = 8'h00;
    localparam logic [7:0]  STATUS_HI_OFS     = 8'h04;
    localparam logic [7:0]  CTRL_OFS          = 8'h08;
    localparam logic [7:0]  INJECT_OFS        = 8'h0C;
    // Status field positions
    localparam int          COMPOUND_LSB      = 0;
    localparam int          UCFAULT_LSB       = 16;
    localparam int          FSMFAULT_LSB      = 20;
    localparam int          VALID_BIT         = 63;
    localparam int          OVER_BIT          = 62;
    // Compound codes
    localparam logic [15:0] CODE_PCU_HW       = 16'h0402;
    localparam logic [15:0] CODE_FW_INTERNAL  = 16'h0406;
    // Microcontroller fault codes
    localparam logic [3:0]  UC_NONE           = 4'h0;
    localparam logic [3:0]  UC_IADDR_RANGE    = 4'h1;
    localparam logic [3:0]  UC_IFETCH_DBE     = 4'h2;
    localparam logic [3:0]  UC_BAD_OPCODE     = 4'h3;
    localparam logic [3:0]  UC_STACK_UNDER    = 4'h4;
    localparam logic [3:0]  UC_STACK_OVER     = 4'h5;
    localparam logic [3:0]  UC_DADDR_RANGE    = 4'h6;
    localparam logic [3:0]  UC_DFETCH_DBE     = 4'h7;
    // State-machine fault codes
    localparam logic [3:0]  FSM_NONE          = 4'h0;
    localparam logic [3:0]  FSM_RESP_TIMEOUT  = 4'h4;
    localparam logic [3:0]  FSM_SMBUS_SMI     = 4'h5;
    localparam logic [3:0]  FSM_BAD_TXN       = 4'h9;
    localparam logic [63:0] STATUS_RESET      = 64'h0;
    localparam logic [31:0] CTRL_RESET        = 32'h0000_0001;
endpackage

// [pces_error_encoder.sv]
`timescale 1ns/1ps
`default_nettype none
// Operation
// [RL1] Power-control errors log into their own status bank, apart from memory banks.
// [RL2] Bits 15:0 take 0402H for hardware errors, 0406H for firmware errors.
// [RL3] Bits 19:16 record one of seven microcontroller faults; others reserved.
// [RL4] Microcontroller codes 01H, 02H, 03H: bad fetch address, fetch RAM DBE, opcode.
// [RL5] Microcontroller codes 04H, 05H, 06H: stack under, stack over, data address.
// [RL6] Microcontroller code 07H marks a double-bit RAM error on data fetch.
// [RL7] Bits 23:20 record one of three state-machine faults; others reserved.
// [RL8] State-machine codes 04H timeout, 05H SMBus interrupt, 09H bad transaction.
// [RL9] Any fault field with no applicable fault is written as zero.
module pces_error_encoder
    import pces_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    // Error sources: one-cycle pulses, same clock
    input  wire logic [6:0]  ucFaultPulse,
    input  wire logic [2:0]  fsmFaultPulse,
    input  wire logic        fwErrorPulse,
    // Classic Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    output logic             errorValid
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rstSync1_q;
    logic rstSync2_q;
    logic rstN;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rstSync1_q <= 1'b0;
            rstSync2_q <= 1'b0;
        end else begin
            rstSync1_q <= 1'b1;
            rstSync2_q <= rstSync1_q;
        end
    end
    assign rstN = rstSync2_q;

    // ------------------------------------------------------------
    // Fault encoding
    // ------------------------------------------------------------
    // Lowest-numbered source wins when several fire in one cycle
    function automatic logic [3:0] ucCode(input logic [6:0] v);
        logic [3:0] c;
        c = UC_NONE;
        if (v[0]) c = UC_IADDR_RANGE;                // RL4
        else if (v[1]) c = UC_IFETCH_DBE;            // RL4
        else if (v[2]) c = UC_BAD_OPCODE;            // RL4
        else if (v[3]) c = UC_STACK_UNDER;           // RL5
        else if (v[4]) c = UC_STACK_OVER;            // RL5
        else if (v[5]) c = UC_DADDR_RANGE;           // RL5
        else if (v[6]) c = UC_DFETCH_DBE;            // RL6
        return c;
    endfunction

    function automatic logic [3:0] fsmCode(input logic [2:0] v);
        logic [3:0] c;
        c = FSM_NONE;
        if (v[0]) c = FSM_RESP_TIMEOUT;              // RL8
        else if (v[1]) c = FSM_SMBUS_SMI;            // RL8
        else if (v[2]) c = FSM_BAD_TXN;              // RL8
        return c;
    endfunction

    logic        hwEvent;
    logic        anyEvent;
    logic [63:0] newStatus;

    always_comb begin
        hwEvent  = (|ucFaultPulse) || (|fsmFaultPulse);
        anyEvent = hwEvent || fwErrorPulse;
        newStatus = 64'h0;                                          // RL9
        newStatus[COMPOUND_LSB +: 16] =
            hwEvent ? CODE_PCU_HW : CODE_FW_INTERNAL;               // RL2
        newStatus[UCFAULT_LSB +: 4]  = ucCode(ucFaultPulse);        // RL3
        newStatus[FSMFAULT_LSB +: 4] = fsmCode(fsmFaultPulse);      // RL7
        newStatus[VALID_BIT] = 1'b1;
    end

    // ------------------------------------------------------------
    // Status bank and bus
    // ------------------------------------------------------------
    logic [63:0] status_q;
    logic [63:0] status_d;
    logic [31:0] ctrl_q;
    logic [31:0] ctrl_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        ack_q;
    logic        ack_d;
    logic        err_q;
    logic        err_d;
    logic        req;
    logic        wrLo;
    logic        mapped;
    logic        logEn;

    assign req   = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
    assign logEn = ctrl_q[0];

    function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                               input logic [31:0] nw,
                                               input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) r[8*i +: 8] = nw[8*i +: 8];
        end
        return r;
    endfunction

    always_comb begin
        status_d = status_q;
        ctrl_d   = ctrl_q;
        rdata_d  = rdata_q;
        ack_d    = 1'b0;
        err_d    = 1'b0;
        mapped   = (wb_adr_i == STATUS_LO_OFS) || (wb_adr_i == STATUS_HI_OFS)
                || (wb_adr_i == CTRL_OFS) || (wb_adr_i == INJECT_OFS);
        wrLo     = 1'b0;
        if (req) begin
            ack_d = mapped;
            err_d = !mapped;
            if (!wb_we_i) begin
                unique case (wb_adr_i)
                    STATUS_LO_OFS: rdata_d = status_q[31:0];
                    STATUS_HI_OFS: rdata_d = status_q[63:32];
                    CTRL_OFS:      rdata_d = ctrl_q;
                    default:       rdata_d = 32'h0;
                endcase
            end else begin
                unique case (wb_adr_i)
                    // Any write to the upper word clears the logged entry
                    STATUS_HI_OFS: wrLo = 1'b1;
                    CTRL_OFS: begin
                        ctrl_d = mergeBytes(ctrl_q, wb_dat_i, wb_sel_i);
                        ctrl_d[31:1] = 31'h0;
                    end
                    default: ;
                endcase
            end
        end
        if (wrLo) status_d = STATUS_RESET;
        // New event wins over a same-cycle clear; first error is kept
        if (anyEvent && logEn) begin                                // RL1
            if (!status_q[VALID_BIT] || wrLo) status_d = newStatus;
            else status_d[OVER_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            status_q <= STATUS_RESET;
            ctrl_q   <= CTRL_RESET;
            rdata_q  <= 32'h0;
            ack_q    <= 1'b0;
            err_q    <= 1'b0;
        end else begin
            status_q <= status_d;
            ctrl_q   <= ctrl_d;
            rdata_q  <= rdata_d;
            ack_q    <= ack_d;
            err_q    <= err_d;
        end
    end

    assign wb_dat_o   = rdata_q;
    assign wb_ack_o   = ack_q;
    assign wb_err_o   = err_q;
    assign errorValid = status_q[VALID_BIT];

endmodule
`default_nettype wire

// [pces_error_encoder_props.sv]
`timescale 1ns/1ps
`default_nettype none
module pces_error_encoder_props
    import pces_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        nrst,
    input wire logic [6:0]  ucFaultPulse,
    input wire logic [2:0]  fsmFaultPulse,
    input wire logic        fwErrorPulse,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    input wire logic        errorValid
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    wire mapped = wb_adr_i[7:4] == 4'h0 && wb_adr_i[1:0] == 2'h0;
    sequence s_rdValid;
        req && !wb_we_i && wb_adr_i == STATUS_LO_OFS && errorValid ##1 wb_ack_o;
    endsequence
    property p_ack; req && mapped |=> wb_ack_o && !wb_err_o; endproperty
    property p_err; req && !mapped |=> wb_err_o && !wb_ack_o; endproperty
    property p_once; wb_ack_o |=> !wb_ack_o; endproperty
    property p_cause; $rose(errorValid) |->
        $past(|{ucFaultPulse, fsmFaultPulse, fwErrorPulse}); endproperty
    property p_code; s_rdValid |->
        wb_dat_o[15:0] inside {CODE_PCU_HW, CODE_FW_INTERNAL}; endproperty
    property p_uc; s_rdValid |-> wb_dat_o[19:16] <= UC_DFETCH_DBE; endproperty
    property p_fsm; s_rdValid |-> wb_dat_o[23:20] inside
        {FSM_NONE, FSM_RESP_TIMEOUT, FSM_SMBUS_SMI, FSM_BAD_TXN}; endproperty
    // Only a bus write may drop a logged error
    property p_keep; $fell(errorValid) |->
        $past(req && wb_we_i && wb_adr_i == STATUS_HI_OFS); endproperty
    a_ack: assert property (p_ack) else $error("missing ack");
    a_err: assert property (p_err) else $error("missing err");
    a_once: assert property (p_once) else $error("ack too long");
    a_cause: assert property (p_cause) else $error("valid uncaused");
    a_code: assert property (p_code) else $error("bad compound");
    a_uc: assert property (p_uc) else $error("bad uc code");
    a_fsm: assert property (p_fsm) else $error("bad fsm code");
    a_keep: assert property (p_keep) else $error("error lost");
endmodule
bind pces_error_encoder pces_error_encoder_props pces_error_encoder_props_i (.*);
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import pces_pkg::*;
;
    logic        clk_sys = 1'b0;
    logic        nrst = 1'b0;
    logic [6:0]  ucFaultPulse = 7'h00;
    logic [2:0]  fsmFaultPulse = 3'h0;
    logic        fwErrorPulse = 1'b0;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [31:0] wb_dat_o, rd;
    logic        wb_ack_o, wb_err_o, errorValid, e;
    int          err_count = 0;
    int          compares = 0;
    logic [3:0]  fc [3] = '{FSM_RESP_TIMEOUT, FSM_SMBUS_SMI, FSM_BAD_TXN};
    pces_error_encoder pces_error_encoder_i (.*);
    always #20 clk_sys = ~clk_sys;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // ------------------------------------------------
    // Classic single cycle; waits for ack or err
    // ------------------------------------------------
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        // Only the watchdog ends a wait that never gets an answer
        do begin
            @(posedge clk_sys);
        end while (!(wb_ack_o || wb_err_o));
        rd = wb_dat_o;
        e  = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic pulse(input logic [6:0] u, input logic [2:0] f,
                         input logic w);
        @(posedge clk_sys);
        ucFaultPulse  <= u;
        fsmFaultPulse <= f;
        fwErrorPulse  <= w;
        @(posedge clk_sys);
        ucFaultPulse  <= 7'h00;
        fsmFaultPulse <= 3'h0;
        fwErrorPulse  <= 1'b0;
    endtask
    task automatic t_codes;
        for (int i = 0; i < 10; i++) begin
            if (i < 7) pulse(7'(1 << i), 3'h0, 1'b0);
            else pulse(7'h00, 3'(1 << (i - 7)), 1'b0);
            wb(1'b0, STATUS_LO_OFS, 32'h0);
            if (i < 7) chk(rd, {12'h000, 4'(i + 1), CODE_PCU_HW});
            else chk(rd, {8'h00, fc[i - 7], 4'h0, CODE_PCU_HW});
            wb(1'b1, STATUS_HI_OFS, 32'h0);
        end
    endtask
    task automatic t_misc;
        wb(1'b0, CTRL_OFS, 32'h0);
        chk(rd, CTRL_RESET);
        wb(1'b0, 8'h10, 32'h0);
        chk({31'h0, e}, 32'h1);
        pulse(7'h00, 3'h0, 1'b1);
        pulse(7'h00, 3'h0, 1'b1);
        wb(1'b0, STATUS_LO_OFS, 32'h0);
        chk(rd, {16'h0000, CODE_FW_INTERNAL});
        wb(1'b0, STATUS_HI_OFS, 32'h0);
        chk(rd, 32'hC000_0000);
        wb(1'b1, CTRL_OFS, 32'h0);
        wb(1'b1, STATUS_HI_OFS, 32'h0);
        pulse(7'h01, 3'h0, 1'b0);
        wb(1'b0, STATUS_HI_OFS, 32'h0);
        chk(rd, STATUS_RESET[63:32]);
        wb(1'b1, CTRL_OFS, 32'h1);
        // Mixed sources: hardware code wins, both fields filled
        pulse(7'h01, 3'h4, 1'b1);
        wb(1'b0, STATUS_LO_OFS, 32'h0);
        chk(rd, {8'h00, FSM_BAD_TXN, UC_IADDR_RANGE, CODE_PCU_HW});
        wb(1'b1, STATUS_HI_OFS, 32'h0);
    endtask
    task automatic test_done;
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #100000;
        err_count++;
        test_done();
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        t_misc();
        t_codes();
        test_done();
    end
endmodule
`default_nettype wire
